// ---- hdl/adc_cfg_defs.vh ----
// Constants for the converter configuration register bank.
// Assumes an 8-bit serial command byte: op[7:5], multi[4], addr[3:0].
`ifndef ADC_CFG_DEFS_VH
`define ADC_CFG_DEFS_VH

// Register addresses
`define ADDR_PRIMARY_CONFIG   4'h0
`define ADDR_TIMING_CONFIG    4'h1
`define ADDR_FIXED_INPUT_SEL  4'h2
`define ADDR_DIFF_SCAN_SEL    4'h3
`define ADDR_SINGLE_SCAN_LO   4'h4
`define ADDR_SINGLE_SCAN_HI   4'h5
`define ADDR_MONITOR_SCAN     4'h6
`define ADDR_PORT_DIRECTION   4'h7
`define ADDR_PORT_VALUE       4'h8
`define ADDR_PART_SIGNATURE   4'h9
`define ADDR_LAST             4'h9

// Reset values
`define RST_PRIMARY_CONFIG    8'h0a
`define RST_TIMING_CONFIG     8'h83
`define RST_FIXED_INPUT_SEL   8'h00
`define RST_DIFF_SCAN_SEL     8'h00
`define RST_SINGLE_SCAN_LO    8'hff
`define RST_SINGLE_SCAN_HI    8'hff
`define RST_MONITOR_SCAN      8'h00
`define RST_PORT_DIRECTION    8'hff
`define RST_PORT_VALUE        8'h00

// Writable-bit masks (zero bits always store and read as zero)
`define MASK_PRIMARY_CONFIG   8'h7e
`define MASK_MONITOR_SCAN     8'h3d

// Primary configuration fields
`define BIT_IDLE_TIMEOUT_SEL  6
`define BIT_SCAN_OR_FIXED     5
`define BIT_EXT_PATH_SEL      4
`define BIT_CLOCK_OUT_EN      3
`define BIT_CHOP_EN           2
`define BIT_STATUS_EN         1

// Timing configuration fields
`define BIT_IDLE_POWER_SEL    7
`define MSB_SETTLE_DELAY      6
`define LSB_SETTLE_DELAY      4
`define MSB_BIAS_CURRENT      3
`define LSB_BIAS_CURRENT      2
`define MSB_CONV_RATE         1
`define LSB_CONV_RATE         0

// Command opcodes
`define OP_REG_READ           3'h2
`define OP_REG_WRITE          3'h3

// Serial idle timeouts in master-clock cycles
`define IDLE_TIMEOUT_LONG     13'd4096
`define IDLE_TIMEOUT_SHORT    13'd256

`endif

// ---- hdl/adc_config_register_bank.v ----
// Configuration register bank of a multiplexed converter with its serial
// command port. Assumes the serial clock idles low, input bits are taken on
// its rising edge and output bits change on its falling edge. All pins are
// sampled by sys_clk, which must run well above twice the serial clock.
//
// Notes on behaviour
// - Command address field selects one of ten registers at addresses 0..9.
// - Primary config resets to 0x0a; bits 7 and 0 stay zero.
// - Serial clock idle 4096 or 256 cycles resets only the serial port.
// - Bit 5 picks scan mode when 0, fixed-channel mode when 1.
// - Scan mode uses the four scan selects, ignores the fixed select.
// - Fixed mode uses the fixed select, ignores scan selects and monitors.
// - Bit 4 picks internal mux path when 0, external inputs when 1.
// - Temperature, supply, gain, reference always internal; offset follows bit 4.
// - Bit 3 drives the clock pin output when 1, default on.
// - Clock source pin high makes clock pin input only, enable ignored.
// - Bit 2 enables external-loop chopping when 1, default off.
// - Bit 1 gates status byte only for direct reads in scan mode.
// - Fixed mode: command reads keep status byte, direct reads drop it.
// - Timing config bit 7 picks standby when 0, sleep when 1.
// - Bits 6..4 set settle delay after channel switch, default zero.
// - Multi-register access increments address, ends after address nine.
`timescale 1ns/10ps
`include "adc_cfg_defs.vh"

module adc_config_register_bank #(
    parameter [7:0] SIGNATURE = 8'h5a  // Arbitrary part signature value
) (
    input  wire       sys_clk_i,
    input  wire       reset_n_i,
    input  wire       cs_n_i,
    input  wire       sclk_i,
    input  wire       sdi_i,
    input  wire       clock_source_pin_i,
    input  wire       internal_reading_i,
    output reg        sdo_o,
    output reg        sdo_oe_o,
    output reg        iface_idle_timeout_select_o,
    output reg        scan_or_fixed_select_o,
    output reg        conv_path_external_o,
    output reg        clock_pin_oe_o,
    output reg        chop_enable_o,
    output reg        direct_read_status_o,
    output reg        idle_power_select_o,
    output reg  [2:0] settle_delay_field_o,
    output reg  [1:0] bias_current_field_o,
    output reg  [1:0] conversion_rate_field_o,
    output reg  [3:0] positive_input_code_o,
    output reg  [3:0] negative_input_code_o,
    output reg  [7:0] diff_scan_mask_o,
    output reg  [15:0] single_scan_mask_o,
    output reg  [7:0] monitor_scan_mask_o,
    output reg  [7:0] port_direction_o,
    output reg  [7:0] port_value_o
);

    // One-hot states of the serial command decoder
    localparam [2:0] ST_CMD    = 3'b001;
    localparam [2:0] ST_DATA   = 3'b010;
    localparam [2:0] ST_IGNORE = 3'b100;

    // Stored registers, one per address below the signature
    reg [7:0] regs_q [0:8];

    // Pin synchronisers: stage 1 feeds only stage 2
    reg [3:0] sync1_q;
    reg [3:0] sync2_q;
    reg       sclk_prev_q;
    wire      sclk_s  = sync2_q[0];
    wire      cs_n_s  = sync2_q[1];
    wire      sdi_s   = sync2_q[2];
    wire      clksrc_s = sync2_q[3];
    wire      sclk_rise = sclk_s & ~sclk_prev_q;
    wire      sclk_fall = ~sclk_s & sclk_prev_q;

    // Serial engine state
    reg [2:0]  state_q;
    reg [2:0]  bit_cnt_q;
    reg [7:0]  rx_shift_q;
    reg [7:0]  tx_shift_q;
    reg [3:0]  addr_q;
    reg        multi_q;
    reg        is_write_q;
    reg [12:0] idle_cnt_q;

    wire [7:0] rx_byte = {rx_shift_q[6:0], sdi_s};
    wire       byte_done = sclk_rise & (bit_cnt_q == 3'h7);
    wire [12:0] idle_limit = regs_q[0][`BIT_IDLE_TIMEOUT_SEL] ?
                             `IDLE_TIMEOUT_SHORT : `IDLE_TIMEOUT_LONG;
    wire       idle_expired = (idle_cnt_q == idle_limit - 13'd1);
    wire       iface_reset = cs_n_s | idle_expired;

    // Read-back value of any address; out of range reads as zero
    function [7:0] read_reg;
        input [3:0] a;
        begin
            if (a == `ADDR_PART_SIGNATURE)
                read_reg = SIGNATURE;
            else if (a < `ADDR_PART_SIGNATURE)
                read_reg = regs_q[a];
            else
                read_reg = 8'h00;
        end
    endfunction

    // Writable bits of each address; zero bits can never be set
    function [7:0] write_mask;
        input [3:0] a;
        begin
            case (a)
                `ADDR_PRIMARY_CONFIG: write_mask = `MASK_PRIMARY_CONFIG;
                `ADDR_MONITOR_SCAN:   write_mask = `MASK_MONITOR_SCAN;
                default:              write_mask = 8'hff;
            endcase
        end
    endfunction

    // Double-flop every pin except reset_n_i and internal_reading_i before use
    always @(posedge sys_clk_i)
    begin
        if (!reset_n_i)
        begin
            sync1_q     <= 4'h2;
            sync2_q     <= 4'h2;
            sclk_prev_q <= 1'b0;
        end
        else
        begin
            sync1_q     <= {clock_source_pin_i, sdi_i, cs_n_i, sclk_i};
            sync2_q     <= sync1_q;
            sclk_prev_q <= sclk_s;
        end
    end

    // Idle timer restarts on any serial clock edge or while deselected
    always @(posedge sys_clk_i)
    begin
        if (!reset_n_i)
            idle_cnt_q <= 13'h0000;
        else if (cs_n_s || sclk_rise || sclk_fall || idle_expired)
            idle_cnt_q <= 13'h0000;
        else
            idle_cnt_q <= idle_cnt_q + 13'd1;
    end

    // Serial command decoder; a timeout clears only this engine
    always @(posedge sys_clk_i)
    begin
        if (!reset_n_i)
        begin
            state_q    <= ST_CMD;
            bit_cnt_q  <= 3'h0;
            rx_shift_q <= 8'h00;
            tx_shift_q <= 8'h00;
            addr_q     <= 4'h0;
            multi_q    <= 1'b0;
            is_write_q <= 1'b0;
        end
        else if (iface_reset)
        begin
            state_q   <= ST_CMD;
            bit_cnt_q <= 3'h0;
            tx_shift_q <= 8'h00;
        end
        else
        begin
            if (sclk_rise)
            begin
                bit_cnt_q  <= bit_cnt_q + 3'h1;
                rx_shift_q <= rx_byte;
            end
            if (sclk_fall && bit_cnt_q != 3'h0)
                tx_shift_q <= {tx_shift_q[6:0], 1'b0};
            if (byte_done)
            begin
                case (state_q)
                    ST_CMD:
                    begin
                        addr_q     <= rx_byte[3:0];
                        multi_q    <= rx_byte[4];
                        is_write_q <= (rx_byte[7:5] == `OP_REG_WRITE);
                        tx_shift_q <= read_reg(rx_byte[3:0]);
                        if (rx_byte[7:5] == `OP_REG_READ ||
                            rx_byte[7:5] == `OP_REG_WRITE)
                            state_q <= ST_DATA;
                        else
                            state_q <= ST_IGNORE;
                    end
                    ST_DATA:
                    begin
                        // Next address is prefetched so its MSB is ready
                        if (multi_q && addr_q < `ADDR_LAST)
                        begin
                            addr_q     <= addr_q + 4'h1;
                            tx_shift_q <= read_reg(addr_q + 4'h1);
                        end
                        else
                        begin
                            state_q    <= ST_CMD;
                            tx_shift_q <= 8'h00;
                        end
                    end
                    ST_IGNORE:
                        state_q <= ST_IGNORE;
                    default:
                        state_q <= ST_CMD;
                endcase
            end
        end
    end

    // Register writes land when a data byte completes
    always @(posedge sys_clk_i)
    begin
        if (!reset_n_i)
        begin
            regs_q[0] <= `RST_PRIMARY_CONFIG;
            regs_q[1] <= `RST_TIMING_CONFIG;
            regs_q[2] <= `RST_FIXED_INPUT_SEL;
            regs_q[3] <= `RST_DIFF_SCAN_SEL;
            regs_q[4] <= `RST_SINGLE_SCAN_LO;
            regs_q[5] <= `RST_SINGLE_SCAN_HI;
            regs_q[6] <= `RST_MONITOR_SCAN;
            regs_q[7] <= `RST_PORT_DIRECTION;
            regs_q[8] <= `RST_PORT_VALUE;
        end
        else if (!iface_reset && byte_done && state_q == ST_DATA &&
                 is_write_q && addr_q < `ADDR_PART_SIGNATURE)
            regs_q[addr_q] <= rx_byte & write_mask(addr_q);
    end

    // Serial output drives only while selected
    always @(posedge sys_clk_i)
    begin
        if (!reset_n_i)
        begin
            sdo_o    <= 1'b0;
            sdo_oe_o <= 1'b0;
        end
        else
        begin
            sdo_o    <= tx_shift_q[7];
            sdo_oe_o <= ~cs_n_s;
        end
    end

    // Decoded controls for the converter, all registered
    always @(posedge sys_clk_i)
    begin
        if (!reset_n_i)
        begin
            iface_idle_timeout_select_o <= 1'b0;
            scan_or_fixed_select_o      <= 1'b0;
            conv_path_external_o        <= 1'b0;
            clock_pin_oe_o              <= 1'b0;
            chop_enable_o               <= 1'b0;
            direct_read_status_o        <= 1'b0;
            idle_power_select_o         <= 1'b0;
            settle_delay_field_o        <= 3'h0;
            bias_current_field_o        <= 2'h0;
            conversion_rate_field_o     <= 2'h0;
            positive_input_code_o       <= 4'h0;
            negative_input_code_o       <= 4'h0;
            diff_scan_mask_o            <= 8'h00;
            single_scan_mask_o          <= 16'h0000;
            monitor_scan_mask_o         <= 8'h00;
            port_direction_o            <= 8'h00;
            port_value_o                <= 8'h00;
        end
        else
        begin
            iface_idle_timeout_select_o <=
                regs_q[0][`BIT_IDLE_TIMEOUT_SEL];
            scan_or_fixed_select_o <= regs_q[0][`BIT_SCAN_OR_FIXED];
            // Monitor readings other than offset never take external path
            conv_path_external_o <= regs_q[0][`BIT_EXT_PATH_SEL] &
                                    ~internal_reading_i;
            // External clock source turns the pin into an input only
            clock_pin_oe_o <= regs_q[0][`BIT_CLOCK_OUT_EN] &
                              ~clksrc_s;
            chop_enable_o <= regs_q[0][`BIT_CHOP_EN];
            // Status byte on direct reads: scan mode and enable bit only
            direct_read_status_o <= regs_q[0][`BIT_STATUS_EN] &
                ~regs_q[0][`BIT_SCAN_OR_FIXED];
            idle_power_select_o <= regs_q[1][`BIT_IDLE_POWER_SEL];
            settle_delay_field_o <=
                regs_q[1][`MSB_SETTLE_DELAY:`LSB_SETTLE_DELAY];
            bias_current_field_o <=
                regs_q[1][`MSB_BIAS_CURRENT:`LSB_BIAS_CURRENT];
            conversion_rate_field_o <=
                regs_q[1][`MSB_CONV_RATE:`LSB_CONV_RATE];
            if (regs_q[0][`BIT_SCAN_OR_FIXED])
            begin
                // Fixed mode: scan selects and monitors are masked off
                positive_input_code_o <= regs_q[2][7:4];
                negative_input_code_o <= regs_q[2][3:0];
                diff_scan_mask_o      <= 8'h00;
                single_scan_mask_o    <= 16'h0000;
                monitor_scan_mask_o   <= 8'h00;
            end
            else
            begin
                positive_input_code_o <= 4'h0;
                negative_input_code_o <= 4'h0;
                diff_scan_mask_o      <= regs_q[3];
                single_scan_mask_o    <= {regs_q[5], regs_q[4]};
                monitor_scan_mask_o   <= regs_q[6];
            end
            port_direction_o <= regs_q[7];
            port_value_o     <= regs_q[8];
        end
    end

endmodule // adc_config_register_bank

// ---- dv/adc_cfg_props.sv ----
// Port checker for the configuration register bank.
// Assumes one sys_clk domain; serial pins reach it through two-flop syncs.
`timescale 1ns/10ps
module adc_cfg_props (
    input logic        sys_clk_i,
    input logic        reset_n_i,
    input logic        cs_n_i,
    input logic        clock_source_pin_i,
    input logic        internal_reading_i,
    input logic        sdo_oe_o,
    input logic        scan_or_fixed_select_o,
    input logic        conv_path_external_o,
    input logic        clock_pin_oe_o,
    input logic        chop_enable_o,
    input logic        direct_read_status_o,
    input logic        idle_power_select_o,
    input logic [2:0]  settle_delay_field_o,
    input logic [3:0]  positive_input_code_o,
    input logic [3:0]  negative_input_code_o,
    input logic [7:0]  diff_scan_mask_o,
    input logic [15:0] single_scan_mask_o,
    input logic [7:0]  monitor_scan_mask_o,
    input logic [7:0]  port_value_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!reset_n_i);
    // Decoded defaults settle two edges after release
    property p_rst_vals;
        $rose(reset_n_i) |-> ##2 direct_read_status_o && idle_power_select_o
            && !chop_enable_o && single_scan_mask_o == 16'hffff;
    endproperty
    a_rst_vals: assert property (p_rst_vals) else $error("bad reset state");
    // Sync latency is three edges, so four cycles of source high suffice
    property p_clk_src;
        clock_source_pin_i [*4] |=> !clock_pin_oe_o;
    endproperty
    a_clk_src: assert property (p_clk_src) else $error("clock pin driven");
    property p_path;
        internal_reading_i |=> !conv_path_external_o;
    endproperty
    a_path: assert property (p_path) else $error("monitor took ext path");
    property p_status;
        direct_read_status_o |-> !scan_or_fixed_select_o;
    endproperty
    a_status: assert property (p_status) else $error("status in fixed");
    // Unused selection set must read as zero at the outputs
    property p_fixed;
        scan_or_fixed_select_o |-> diff_scan_mask_o == 8'h00
            && single_scan_mask_o == 16'h0000 && monitor_scan_mask_o == 8'h00;
    endproperty
    a_fixed: assert property (p_fixed) else $error("scan masks in fixed");
    property p_scan;
        !scan_or_fixed_select_o |-> {positive_input_code_o,
            negative_input_code_o} == 8'h00;
    endproperty
    a_scan: assert property (p_scan) else $error("fixed codes in scan");
    property p_sdo;
        cs_n_i [*4] |=> !sdo_oe_o;
    endproperty
    a_sdo: assert property (p_sdo) else $error("sdo driven deselected");
    // No write can land while the port has been deselected for long
    property p_hold;
        cs_n_i [*8] |=> $stable(settle_delay_field_o)
            && $stable(idle_power_select_o) && $stable(port_value_o);
    endproperty
    a_hold: assert property (p_hold) else $error("config moved idle");
endmodule // adc_cfg_props

bind adc_config_register_bank adc_cfg_props u_props (.*);

// ---- dv/serial_host_model.sv ----
// Serial host model driving the command port of the register bank.
// Assumes a 25 MHz sys_clk; the serial clock runs 320 ns only in frames.
`timescale 1ns/10ps
module serial_host_model (
    input  logic       sys_clk_i,
    input  logic       sdo_i,
    output logic       cs_n_o = 1'b1,
    output logic       sclk_o = 1'b0,
    output logic       sdi_o = 1'b0,
    output logic       rx_valid_o = 1'b0,
    output logic [7:0] rx_byte_o = 8'h00
);
    // Select, then let the device's synchronisers see it
    task automatic start;
        @(posedge sys_clk_i);
        cs_n_o <= 1'b0;
        repeat (4) @(posedge sys_clk_i);
    endtask
    // Released data line flips so a stale level is never trusted
    task automatic stop;
        @(posedge sys_clk_i);
        cs_n_o <= 1'b1;
        sdi_o <= ~sdi_o;
        repeat (8) @(posedge sys_clk_i);
    endtask
    // Four cycles low, four high; sampled just before the next fall
    task automatic pulse(input logic b, output logic s);
        @(posedge sys_clk_i);
        sclk_o <= 1'b0;
        sdi_o <= b;
        repeat (4) @(posedge sys_clk_i);
        sclk_o <= 1'b1;
        repeat (3) @(posedge sys_clk_i);
        s = sdo_i;
    endtask
    // Whole byte, most significant bit first; read bytes are reported
    task automatic xfer(input logic [7:0] tx, input logic rd);
        logic [7:0] rx;
        for (int k = 7; k >= 0; k--)
            pulse(tx[k], rx[k]);
        if (rd)
        begin
            rx_byte_o <= rx;
            rx_valid_o <= 1'b1;
            @(posedge sys_clk_i);
            rx_valid_o <= 1'b0;
        end
    endtask
endmodule // serial_host_model

// ---- dv/adc_config_register_bank_tb_top.sv ----
// Self-checking bench for the configuration register bank.
// Assumes the host model frames bytes and reports every byte it reads.
`timescale 1ns/10ps
`include "adc_cfg_defs.vh"
module adc_config_register_bank_tb_top;
    localparam logic [7:0] SIG = 8'ha7; // Arbitrary signature value
    localparam logic [7:0] RST [0:8] = '{8'h0a, 8'h83, 8'h00, 8'h00, 8'hff,
                                         8'hff, 8'h00, 8'hff, 8'h00};
    logic        sys_clk_i, reset_n_i, cs_n_i, sclk_i, sdi_i, sdo_o, sdo_oe_o;
    logic        clock_source_pin_i, internal_reading_i, rx_valid, bit_d;
    logic        iface_idle_timeout_select_o, scan_or_fixed_select_o;
    logic        conv_path_external_o, clock_pin_oe_o, chop_enable_o;
    logic        direct_read_status_o, idle_power_select_o;
    logic [1:0]  bias_current_field_o, conversion_rate_field_o;
    logic [2:0]  settle_delay_field_o;
    logic [3:0]  positive_input_code_o, negative_input_code_o;
    logic [7:0]  diff_scan_mask_o, monitor_scan_mask_o, port_direction_o;
    logic [7:0]  port_value_o, rx_byte, r0, mdl [0:9], exp_q [$];
    logic [15:0] single_scan_mask_o;
    integer      n_mismatch, total_checks, seed, i;
    adc_config_register_bank #(.SIGNATURE(SIG)) dut (.*);
    serial_host_model host (
        .sys_clk_i  (sys_clk_i),
        .sdo_i      (sdo_o),
        .cs_n_o     (cs_n_i),
        .sclk_o     (sclk_i),
        .sdi_o      (sdi_i),
        .rx_valid_o (rx_valid),
        .rx_byte_o  (rx_byte)
    );
    // 25 MHz system clock
    initial
    begin
        sys_clk_i = 1'b0;
        forever #20 sys_clk_i = ~sys_clk_i;
    end
    // Side pins wander; internal readings only while chopping is off
    always @(posedge sys_clk_i)
    begin
        if (($random(seed) & 63) == 0)
            clock_source_pin_i <= ~clock_source_pin_i;
        internal_reading_i <= ~mdl[0][2] & seed[3];
    end
    // Case inequality, so an unknown never passes
    task automatic chk(input logic [7:0] got, input logic [7:0] want);
        total_checks++;
        if (got !== want)
        begin
            n_mismatch++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, want);
        end
    endtask
    task automatic rd(input logic [3:0] a, input int n);
        host.xfer({3'h2, n > 1, a}, 1'b0);
        for (int j = 0; j < n; j++)
        begin
            exp_q.push_back(a + j > 9 ? 8'h00 : mdl[a + j]);
            host.xfer(8'h00, 1'b1);
        end
    endtask
    // Model keeps only what the device may store
    task automatic wr(input logic [3:0] a, input int n);
        logic [7:0] d;
        host.xfer({3'h3, n > 1, a}, 1'b0);
        for (int j = 0; j < n; j++)
        begin
            d = (a + j == 0) ? r0 : 8'($random(seed));
            host.xfer(d, 1'b0);
            if (a + j < 9)
                mdl[a + j] = d & ((a + j == 0) ? `MASK_PRIMARY_CONFIG :
                    (a + j == 6) ? `MASK_MONITOR_SCAN : 8'hff);
        end
    endtask
    task automatic do_reset;
        for (int j = 0; j < 9; j++)
            mdl[j] = RST[j];
        mdl[9] = SIG;
        reset_n_i <= 1'b0;
        repeat (5) @(posedge sys_clk_i);
        reset_n_i <= 1'b1;
        repeat (6) @(posedge sys_clk_i);
    endtask
    task automatic end_sim;
        if (exp_q.size() != 0)
            n_mismatch++;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Each reported read byte meets the oldest expectation
    always @(posedge sys_clk_i)
        if (rx_valid && exp_q.size() == 0)
            n_mismatch++;
        else if (rx_valid)
            chk(rx_byte, exp_q.pop_front());
    // A hung run still ends in the verdict
    initial
    begin
        repeat (60000) @(posedge sys_clk_i);
        n_mismatch++;
        end_sim();
    end
    initial
    begin
        seed = 32'hd44d9c20;
        n_mismatch = 0;
        total_checks = 0;
        clock_source_pin_i = 1'b0;
        internal_reading_i = 1'b0;
        r0 = 8'h00;
        do_reset();
        host.start();
        rd(4'h0, 10);
        rd(4'h1, 1);
        host.stop();
        $display("test reset_map done");
        host.start();
        wr(4'h2, 8);
        rd(4'h2, 8);
        rd(4'ha, 1);
        host.stop();
        $display("test multi_access done");
        repeat (6)
        begin
            r0 = 8'($random(seed));
            host.start();
            wr(4'h0, 1);
            wr(4'h1, 1);
            rd(4'h0, 1);
            host.stop();
            chk(scan_or_fixed_select_o, r0[5]);
            chk(chop_enable_o, r0[2]);
            chk(direct_read_status_o, r0[1] & ~r0[5]);
            chk(diff_scan_mask_o, r0[5] ? 8'h00 : mdl[3]);
            chk(positive_input_code_o, r0[5] ? mdl[2][7:4] : 4'h0);
            chk(settle_delay_field_o, mdl[1][6:4]);
            chk(idle_power_select_o, mdl[1][7]);
            chk(iface_idle_timeout_select_o, r0[6]);
            chk(bias_current_field_o, mdl[1][3:2]);
            chk(conversion_rate_field_o, mdl[1][1:0]);
            chk(negative_input_code_o, r0[5] ? mdl[2][3:0] : 4'h0);
            chk(single_scan_mask_o[15:8], r0[5] ? 8'h00 : mdl[5]);
            chk(single_scan_mask_o[7:0], r0[5] ? 8'h00 : mdl[4]);
            chk(monitor_scan_mask_o, r0[5] ? 8'h00 : mdl[6]);
            chk(port_direction_o, mdl[7]);
            chk(port_value_o, mdl[8]);
            if (r0[2])
                chk(conv_path_external_o, r0[4]);
        end
        $display("test field_decode done");
        // Short idle limit drops a partial byte mid-frame
        r0 = 8'h4a;
        host.start();
        wr(4'h0, 1);
        for (i = 0; i < 3; i++)
            host.pulse(1'b1, bit_d);
        repeat (300) @(posedge sys_clk_i);
        rd(4'h1, 1);
        host.stop();
        $display("test idle_timeout done");
        do_reset();
        host.start();
        rd(4'h0, 10);
        host.stop();
        $display("test second_reset done");
        end_sim();
    end
endmodule // adc_config_register_bank_tb_top
